// *** alarm_input_module.sv ***
`timescale 1ns/1ps
module alarm_input_module #(
   parameter int NUM_SLAVES_MAX = 7
) (
   // clock and reset
   input wire logic sys_clk_in,
   input wire logic resetn_in,
   // process inputs
   input wire logic [alarm_input_pkg::NUM_CH-1:0] din_in,
   // i/o bus, byte reads
   input wire logic io_rd_in,
   input wire logic [7:0] io_addr_in,
   output logic [alarm_input_pkg::BYTE_W-1:0] io_data_out,
   output logic io_data_oe_n_out,
   output logic io_ack_out,
   // configuration switches and jumpers
   input wire logic [7:0] base_addr_in,
   input wire logic [alarm_input_pkg::NUM_BYTES-1:0] edge_polarity_switches_in,
   input wire logic [alarm_input_pkg::IRQ_LINES-1:0] interrupt_line_switches_in,
   input wire logic [alarm_input_pkg::ALARM_BIT_W-1:0] alarm_bit_switches_in,
   input wire logic [alarm_input_pkg::ALARM_BIT_W-1:0] slave_count_in,
   input wire logic chain_jumper_in,
   input wire logic alarm_byte_jumper_in,
   // alarm signalling
   input wire logic [alarm_input_pkg::SHARE_BITS-1:0] slave_alarm_in,
   output logic [alarm_input_pkg::IRQ_LINES-1:0] irq_line_out,
   output logic alarm_req_out,
   output logic chain_alarm_out,
   // status
   output logic inhibit_out,
   output logic seq_error_out
);
   import alarm_input_pkg::*;

   // ****************
   // decode helpers
   // ****************
   function automatic logic in_window(input logic [7:0] addr, input logic [7:0] base);
      logic [8:0] diff;
      diff = {1'b0, addr} - {1'b0, base};
      in_window = (addr >= base) && (diff < 9'(NUM_BYTES));
   endfunction

   function automatic logic [OFFS_W-1:0] offset_of(input logic [7:0] addr, input logic [7:0] base);
      logic [7:0] diff;
      diff = addr - base;
      offset_of = diff[OFFS_W-1:0];
   endfunction

   // ****************
   // configuration decode
   // ****************
   logic shared_mode;
   logic is_master;
   logic own_hit;
   logic shared_hit;
   logic [OFFS_W-1:0] rd_offs;
   logic scan_done;
   logic [SHARE_BITS-1:0] slave_mask;
   logic [SHARE_BITS-1:0] share_byte;

   assign shared_mode = alarm_byte_jumper_in;
   // bit zero with chain jumper fitted makes the master
   assign is_master = shared_mode && chain_jumper_in && (alarm_bit_switches_in == MASTER_BIT);
   assign own_hit = io_rd_in && in_window(io_addr_in, base_addr_in);
   assign shared_hit = io_rd_in && shared_mode && is_master && (io_addr_in == SHARED_ADDR);
   assign rd_offs = offset_of(io_addr_in, base_addr_in);

   // ****************
   // scan sequence and input freeze
   // ****************
   scan_state_type scan_q;
   logic [OFFS_W-1:0] expect_q;
   logic inhibit_q;
   logic seq_err_q;

   always_ff @(posedge sys_clk_in) begin
      if (!resetn_in) begin
         scan_q <= SCAN_IDLE;
         expect_q <= FIRST_OFFS;
      end else if (own_hit) begin
         unique case (scan_q)
            SCAN_IDLE: begin
               if (rd_offs == FIRST_OFFS) begin
                  scan_q <= SCAN_HELD;
                  expect_q <= FIRST_OFFS + 2'h1;
               end
            end
            SCAN_HELD: begin
               if (rd_offs == FIRST_OFFS) begin
                  expect_q <= FIRST_OFFS + 2'h1;
               end else if (rd_offs == LAST_OFFS && expect_q == LAST_OFFS) begin
                  scan_q <= SCAN_IDLE;
                  expect_q <= FIRST_OFFS;
               end else if (rd_offs == expect_q) begin
                  expect_q <= expect_q + 2'h1;
               end
            end
         endcase
      end
   end

   assign scan_done = own_hit && scan_q == SCAN_HELD && rd_offs == LAST_OFFS && expect_q == LAST_OFFS;

   // freeze on byte zero, release on byte three whatever came between
   always_ff @(posedge sys_clk_in) begin
      if (!resetn_in) begin
         inhibit_q <= 1'b0;
      end else if (own_hit && rd_offs == FIRST_OFFS) begin
         inhibit_q <= 1'b1;
      end else if (own_hit && rd_offs == LAST_OFFS) begin
         inhibit_q <= 1'b0;
      end
   end

   // sticky flag for reads out of order or repeated; cleared by a clean scan
   always_ff @(posedge sys_clk_in) begin
      if (!resetn_in) begin
         seq_err_q <= 1'b0;
      end else if (own_hit && !(rd_offs == FIRST_OFFS) &&
                   (scan_q == SCAN_IDLE || rd_offs != expect_q)) begin
         seq_err_q <= 1'b1;
      end else if (scan_done) begin
         seq_err_q <= 1'b0;
      end
   end

   // ****************
   // input sampling and edges
   // ****************
   logic [NUM_CH-1:0] sample_q;
   logic [NUM_CH-1:0] pending_q;
   edge_sense_if sense ();

   always_ff @(posedge sys_clk_in) begin
      if (!resetn_in) begin
         sample_q <= CH_RST;
      end else if (!inhibit_q) begin
         sample_q <= din_in;
      end
   end

   assign sense.sample = sample_q;
   assign sense.rising = edge_polarity_switches_in;

   edge_sense u_edge (
      .sys_clk_in(sys_clk_in),
      .resetn_in(resetn_in),
      .sense(sense)
   );

   // a new edge in the clearing cycle stays pending
   always_ff @(posedge sys_clk_in) begin
      if (!resetn_in) begin
         pending_q <= CH_RST;
      end else if (scan_done) begin
         pending_q <= sense.edge_hit;
      end else begin
         pending_q <= pending_q | sense.edge_hit;
      end
   end

   // ****************
   // alarm signalling
   // ****************
   logic own_alarm;
   logic [IRQ_LINES-1:0] irq_q;
   logic req_q;
   logic chain_q;

   assign own_alarm = |pending_q;

   // master only counts slaves up to the configured number
   genvar s;
   generate
      for (s = 0; s < SHARE_BITS; s++) begin : g_share
         if (s == 0) begin : g_own
            assign slave_mask[s] = 1'b0;
         end else begin : g_slave
            assign slave_mask[s] = (s <= NUM_SLAVES_MAX) && (ALARM_BIT_W'(s) <= slave_count_in);
         end
      end
   endgenerate

   assign share_byte = (slave_alarm_in & slave_mask) | {{(SHARE_BITS-1){1'b0}}, own_alarm};

   always_ff @(posedge sys_clk_in) begin
      if (!resetn_in) begin
         irq_q <= IRQ_RST;
      end else if (shared_mode) begin
         irq_q <= IRQ_RST;
      end else begin
         irq_q <= interrupt_line_switches_in & {IRQ_LINES{own_alarm}};
      end
   end

   // level request: the alarm routine sees it until every source is scanned
   always_ff @(posedge sys_clk_in) begin
      if (!resetn_in) begin
         req_q <= 1'b0;
      end else if (shared_mode) begin
         req_q <= is_master && (|share_byte);
      end else begin
         req_q <= own_alarm;
      end
   end

   // slaves hand their alarm to the master through the chain
   always_ff @(posedge sys_clk_in) begin
      if (!resetn_in) begin
         chain_q <= 1'b0;
      end else begin
         chain_q <= shared_mode && !is_master && own_alarm;
      end
   end

   // ****************
   // read data path
   // ****************
   logic [BYTE_W-1:0] data_q;
   logic oe_n_q;
   logic ack_q;

   always_ff @(posedge sys_clk_in) begin
      if (!resetn_in) begin
         data_q <= DATA_RST;
         oe_n_q <= 1'b1;
         ack_q <= 1'b0;
      end else if (shared_hit) begin
         data_q <= share_byte;
         oe_n_q <= 1'b0;
         ack_q <= 1'b1;
      end else if (own_hit) begin
         data_q <= (rd_offs == FIRST_OFFS) ? din_in[BYTE_W-1:0] :
                   sample_q[rd_offs*BYTE_W +: BYTE_W];
         oe_n_q <= 1'b0;
         ack_q <= 1'b1;
      end else begin
         data_q <= DATA_RST;
         oe_n_q <= 1'b1;
         ack_q <= 1'b0;
      end
   end

   // ****************
   // outputs
   // ****************
   assign io_data_out = data_q;
   assign io_data_oe_n_out = oe_n_q;
   assign io_ack_out = ack_q;
   assign irq_line_out = irq_q;
   assign alarm_req_out = req_q;
   assign chain_alarm_out = chain_q;
   assign inhibit_out = inhibit_q;
   assign seq_error_out = seq_err_q;
endmodule

// *** alarm_input_pkg.sv ***
package alarm_input_pkg;
   // ****************
   // sizes
   // ****************
   localparam int BYTE_W = 8;
   localparam int NUM_BYTES = 4;
   localparam int NUM_CH = BYTE_W * NUM_BYTES;
   localparam int IRQ_LINES = 4;
   localparam int SHARE_BITS = 8;
   localparam int ALARM_BIT_W = 3;
   localparam int OFFS_W = 2;

   // ****************
   // addresses and offsets
   // ****************
   localparam logic [7:0] SHARED_ADDR = 8'h00;
   localparam logic [OFFS_W-1:0] FIRST_OFFS = 2'h0;
   localparam logic [OFFS_W-1:0] LAST_OFFS = 2'h3;
   localparam logic [ALARM_BIT_W-1:0] MASTER_BIT = 3'h0;

   // ****************
   // reset values
   // ****************
   localparam logic [BYTE_W-1:0] DATA_RST = 8'h00;
   localparam logic [NUM_CH-1:0] CH_RST = 32'h00000000;
   localparam logic [IRQ_LINES-1:0] IRQ_RST = 4'h0;

   // ****************
   // scan sequence
   // ****************
   typedef enum logic [1:0] {
      SCAN_IDLE,
      SCAN_HELD
   } scan_state_type;
endpackage

// *** edge_sense_if.sv ***
`timescale 1ns/1ps
interface edge_sense_if;
   import alarm_input_pkg::*;
   logic [NUM_CH-1:0] sample;
   logic [NUM_BYTES-1:0] rising;
   logic [NUM_CH-1:0] edge_hit;

   modport detector (
      input sample,
      input rising,
      output edge_hit
   );
   modport user (
      output sample,
      output rising,
      input edge_hit
   );
endinterface

// *** edge_sense.sv ***
`timescale 1ns/1ps
module edge_sense (
   // clock and reset
   input wire logic sys_clk_in,
   input wire logic resetn_in,
   // channel samples and edge pulses
   edge_sense_if.detector sense
);
   import alarm_input_pkg::*;

   // ****************
   // per channel edge detection
   // ****************
   logic [NUM_CH-1:0] prev_q;
   logic [NUM_CH-1:0] hit_d;

   // previous value only moves when the sample moves, so a frozen input
   // circuit holds back edges until it is released rather than losing them
   always_ff @(posedge sys_clk_in) begin
      if (!resetn_in) begin
         prev_q <= CH_RST;
      end else begin
         prev_q <= sense.sample;
      end
   end

   genvar b;
   generate
      for (b = 0; b < NUM_BYTES; b++) begin : g_byte
         // one polarity per byte, shared by its eight channels
         assign hit_d[b*BYTE_W +: BYTE_W] = sense.rising[b] ?
            (sense.sample[b*BYTE_W +: BYTE_W] & ~prev_q[b*BYTE_W +: BYTE_W]) :
            (~sense.sample[b*BYTE_W +: BYTE_W] & prev_q[b*BYTE_W +: BYTE_W]);
      end
   endgenerate

   assign sense.edge_hit = hit_d;
endmodule

// *** alarm_input_chk.sv ***
`timescale 1ns/1ps
module alarm_input_chk #(
   parameter int NUM_SLAVES_MAX = 7
) (
   // clock and reset
   input wire logic sys_clk_in,
   input wire logic resetn_in,
   // watched ports
   input wire logic [alarm_input_pkg::NUM_CH-1:0] din_in,
   input wire logic io_rd_in,
   input wire logic [7:0] io_addr_in,
   input wire logic [alarm_input_pkg::BYTE_W-1:0] io_data_out,
   input wire logic io_data_oe_n_out,
   input wire logic io_ack_out,
   input wire logic [7:0] base_addr_in,
   input wire logic [alarm_input_pkg::NUM_BYTES-1:0] edge_polarity_switches_in,
   input wire logic alarm_byte_jumper_in,
   input wire logic [alarm_input_pkg::IRQ_LINES-1:0] irq_line_out,
   input wire logic alarm_req_out,
   input wire logic inhibit_out
);
   import alarm_input_pkg::*;
   logic [7:0] offs;
   logic own_rd;
   // address wrap above 255 is not modelled
   assign offs = io_addr_in - base_addr_in;
   assign own_rd = io_rd_in && (offs < 8'h04);
   default clocking @(posedge sys_clk_in); endclocking
   default disable iff (!resetn_in);
   // ****
   // edge on channel 0 with the bus left alone
   // ****
   sequence rise_seen;
      !inhibit_out && !io_rd_in && !alarm_byte_jumper_in && edge_polarity_switches_in[0] && $rose(din_in[0])
         ##1 (!io_rd_in) [*3];
   endsequence
   a_ack_latency: assert property (own_rd |=> io_ack_out)
      else $error("own byte read not acknowledged");
   a_no_stray_ack: assert property (!io_rd_in |=> !io_ack_out)
      else $error("acknowledge without a read");
   a_oe_with_ack: assert property (io_ack_out |-> !io_data_oe_n_out)
      else $error("data not driven with acknowledge");
   a_idle_bus_quiet: assert property (!io_ack_out |-> io_data_oe_n_out && io_data_out == 8'h00)
      else $error("data driven outside acknowledge");
   a_first_freezes: assert property (own_rd && offs == 8'h00 |=> inhibit_out && io_data_out == $past(din_in[7:0]))
      else $error("first byte read did not freeze");
   a_last_releases: assert property (own_rd && offs == 8'h03 |=> !inhibit_out)
      else $error("last byte read did not release");
   a_shared_lines_off: assert property (alarm_byte_jumper_in && $past(alarm_byte_jumper_in) |-> irq_line_out == 4'h0)
      else $error("interrupt line active in shared mode");
   a_req_held: assert property ($fell(alarm_req_out) |-> $past(io_ack_out))
      else $error("alarm request dropped without a read");
   a_edge_raises: assert property (rise_seen |-> ##[0:2] alarm_req_out)
      else $error("rising edge raised no alarm");
endmodule
bind alarm_input_module alarm_input_chk #(.NUM_SLAVES_MAX(NUM_SLAVES_MAX)) chk (.sys_clk_in(sys_clk_in),
   .resetn_in(resetn_in), .din_in(din_in), .io_rd_in(io_rd_in), .io_addr_in(io_addr_in),
   .io_data_out(io_data_out), .io_data_oe_n_out(io_data_oe_n_out), .io_ack_out(io_ack_out),
   .base_addr_in(base_addr_in), .edge_polarity_switches_in(edge_polarity_switches_in),
   .alarm_byte_jumper_in(alarm_byte_jumper_in), .irq_line_out(irq_line_out), .alarm_req_out(alarm_req_out),
   .inhibit_out(inhibit_out));

// *** alarm_host.sv ***
`timescale 1ns/1ps
module alarm_host (
   // clock and bus answer
   input wire logic sys_clk_in,
   input wire logic [7:0] base_addr_in,
   input wire logic io_ack_in,
   input wire logic [7:0] io_data_in,
   // bus request
   output logic io_rd_out,
   output logic [7:0] io_addr_out
);
   initial begin
      io_rd_out = 1'b0;
      io_addr_out = 8'h00;
   end
   // one pulse per byte and no retry: a repeated read of byte 1, 2 or 3 sets the sequence error
   task automatic read_byte(input logic [7:0] a, output logic [7:0] d, output logic got);
      int n;
      @(negedge sys_clk_in);
      io_rd_out = 1'b1;
      io_addr_out = a;
      @(negedge sys_clk_in);
      io_rd_out = 1'b0;
      io_addr_out = ~a;
      got = 1'b0;
      d = 8'h00;
      for (n = 0; n < 3 && !got; n++) begin
         if (io_ack_in === 1'b1) begin
            got = 1'b1;
            d = io_data_in;
         end else begin
            @(negedge sys_clk_in);
         end
      end
   endtask
   // base above 127 keeps the bytes out of the process image
   task automatic scan(output logic [31:0] w);
      logic [7:0] d;
      logic g;
      w = 32'h00000000;
      for (int k = 0; k < 4; k++) begin
         read_byte(base_addr_in + 8'(k), d, g);
         // an unanswered byte is poisoned so that no compare can pass on it
         w[8*k +: 8] = g ? d : 8'hXX;
      end
   endtask
endmodule

// *** testbench.sv ***
`timescale 1ns/1ps
module testbench;
   import alarm_input_pkg::*;
   logic sys_clk_in = 1'b0;
   logic resetn_in = 1'b0;
   logic [NUM_CH-1:0] din = 32'hFF00FF00;
   logic [7:0] base = 8'h80;
   logic [3:0] pol = 4'h5;
   logic [3:0] irq_sel = 4'h5;
   logic [2:0] abit = 3'h0;
   logic [2:0] scount = 3'h3;
   logic chain = 1'b1;
   logic shared = 1'b0;
   logic [7:0] slaves = 8'hFF;
   logic rd, ack, oe_n, req, chain_alarm, inhibit, seq_err;
   logic [7:0] addr, data;
   logic [3:0] irq;
   int fail_count = 0;
   int tests_run = 0;
   always #20 sys_clk_in = ~sys_clk_in;
   alarm_input_module dut (.sys_clk_in(sys_clk_in), .resetn_in(resetn_in), .din_in(din), .io_rd_in(rd),
      .io_addr_in(addr), .io_data_out(data), .io_data_oe_n_out(oe_n), .io_ack_out(ack), .base_addr_in(base),
      .edge_polarity_switches_in(pol), .interrupt_line_switches_in(irq_sel), .alarm_bit_switches_in(abit),
      .slave_count_in(scount), .chain_jumper_in(chain), .alarm_byte_jumper_in(shared), .slave_alarm_in(slaves),
      .irq_line_out(irq), .alarm_req_out(req), .chain_alarm_out(chain_alarm), .inhibit_out(inhibit),
      .seq_error_out(seq_err));
   alarm_host host (.sys_clk_in(sys_clk_in), .base_addr_in(base), .io_ack_in(ack), .io_data_in(data),
      .io_rd_out(rd), .io_addr_out(addr));
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      tests_run++;
      if (seen !== exp) begin
         fail_count++;
         $display("mismatch at %0t: saw %h want %h", $time, seen, exp);
      end
   endtask
   task automatic report_and_stop;
      $display("checks %0d mismatches %0d", tests_run, fail_count);
      if (fail_count == 0 && tests_run > 0) begin
         $display("ALL CHECKS OK");
      end else begin
         $display("CHECKS NOT OK");
      end
      $finish;
   endtask
   task automatic idle(input int n);
      repeat (n) @(negedge sys_clk_in);
   endtask
   task automatic flip(input int b);
      @(negedge sys_clk_in);
      din[b] = ~din[b];
   endtask
   // level wait, so a held request is never missed
   task automatic wait_alarm(input logic from_chain);
      for (int n = 0; n < 10; n++) begin
         @(negedge sys_clk_in);
         if ((from_chain ? chain_alarm : req) === 1'b1) return;
      end
      fail_count++;
      $display("mismatch at %0t: no alarm", $time);
      report_and_stop();
   endtask
   task automatic t_edges;
      logic [31:0] w;
      for (int k = 0; k < 4; k++) begin
         flip(8 * k);
         wait_alarm(1'b0);
         check(irq, 4'h5);
         host.scan(w);
         check(w, din);
         idle(2);
         check(req, 1'b0);
         flip(8 * k);
         idle(6);
         check(req, 1'b0);
      end
   endtask
   task automatic t_freeze;
      logic [7:0] d;
      logic g;
      logic [31:0] w;
      host.read_byte(base, d, g);
      check({inhibit, d}, {1'b1, din[7:0]});
      flip(8);
      host.read_byte(base + 8'h01, d, g);
      check(d, 8'hFF);
      host.read_byte(base + 8'h02, d, g);
      host.read_byte(base + 8'h03, d, g);
      check(inhibit, 1'b0);
      wait_alarm(1'b0);
      host.scan(w);
      flip(8);
   endtask
   task automatic t_order;
      logic [7:0] d;
      logic g;
      logic [31:0] w;
      flip(16);
      wait_alarm(1'b0);
      host.read_byte(base, d, g);
      host.read_byte(base + 8'h02, d, g);
      host.read_byte(base + 8'h03, d, g);
      idle(2);
      check({seq_err, req, inhibit}, 3'b110);
      host.scan(w);
      idle(2);
      check({seq_err, req}, 2'b00);
      flip(16);
      host.read_byte(base + 8'h04, d, g);
      check(g, 1'b0);
      host.read_byte(8'h00, d, g);
      check(g, 1'b0);
   endtask
   task automatic t_shared;
      logic [7:0] d;
      logic g;
      logic [31:0] w;
      @(negedge sys_clk_in);
      // one master and three slaves in one rack, well under eight sources
      shared = 1'b1;
      idle(2);
      host.read_byte(8'h00, d, g);
      check({g, d}, 9'h10E);
      flip(0);
      wait_alarm(1'b0);
      check(irq, 4'h0);
      host.read_byte(8'h00, d, g);
      check({g, d}, 9'h10F);
      host.scan(w);
      abit = 3'h2;
      chain = 1'b0;
      flip(0);
      flip(0);
      wait_alarm(1'b1);
      check(req, 1'b0);
      host.read_byte(8'h00, d, g);
      check(g, 1'b0);
      host.scan(w);
      idle(2);
      check(chain_alarm, 1'b0);
   endtask
   initial begin
      idle(16);
      resetn_in = 1'b1;
      idle(1);
      check({ack, oe_n, req, inhibit, irq}, 8'h40);
      t_edges();
      t_freeze();
      t_order();
      t_shared();
      report_and_stop();
   end
endmodule
